/* File: src/tag_proto_ctrl.sv */
// Tag state machine, anticollision and system area protocol controller
`timescale 1ns/100ps
module tag_proto_ctrl
  import tag_ctrl_pkg::*;
#(
  parameter logic        MASK_EN   = 1'b0,
  parameter logic [31:0] SYS_RESET = 32'hffff_ffff,
  // Arbitrary serial number
  parameter logic [63:0] UID_VALUE = 64'h0123_4567_89ab_cdef
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       RX_SOF_I,
  input  wire logic       RX_VALID_I,
  input  wire logic [7:0] RX_DATA_I,
  input  wire logic       RX_EOF_I,
  input  wire logic       RX_CRC_OK_I,
  input  wire logic       TX_READY_I,
  output logic            TX_VALID_O,
  output logic      [1:0] TX_KIND_O,
  output logic      [7:0] TX_DATA_O,
  output logic      [2:0] STATE_O,
  output logic      [7:0] HANDLE_O,
  output logic     [15:0] LOCK_O
);
  tag_state_t          state_ff;
  tag_state_t          nxt_state;
  tx_state_t           tx_ff;
  logic                in_frame_ff;
  logic [2:0]          rx_cnt_ff;
  logic [7:0]          buf_ff [0:RX_BYTES-1];
  logic [HANDLE_W-1:0] handle_ff;
  logic [15:0]         lfsr_ff;
  logic [WORD_W-1:0]   sys_ff;
  logic [LOCK_W-1:0]   lock_ff;
  logic [63:0]         ans_ff;
  logic [3:0]          ans_cnt_ff;
  logic                fetch_ff;
  logic                fetch_sys_ff;
  logic [WORD_W-1:0]   mem_rdata;

  // Receive side: bytes collected between start and end of frame
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      in_frame_ff <= 1'b0;
      rx_cnt_ff   <= 3'h0;
    end else if (RX_SOF_I) begin
      in_frame_ff <= 1'b1;
      rx_cnt_ff   <= 3'h0;
    end else if (RX_EOF_I) begin
      in_frame_ff <= 1'b0;
    end else if (RX_VALID_I && in_frame_ff && rx_cnt_ff != LEN_OVER) begin
      rx_cnt_ff <= rx_cnt_ff + 3'h1;
    end
  end

  for (genvar i = 0; i < RX_BYTES; i++) begin : g_rx
    always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
        buf_ff[i] <= 8'h00;
      end else if (RX_VALID_I && in_frame_ff && rx_cnt_ff == 3'(i)) begin
        buf_ff[i] <= RX_DATA_I;
      end
    end
  end

  // Frame acceptance and command decode
  wire       busy     = (tx_ff != TX_IDLE) || fetch_ff;
  wire       frame_ok = RX_EOF_I && in_frame_ff && RX_CRC_OK_I && !busy;
  wire [7:0] b0       = buf_ff[0];
  wire [7:0] b1       = buf_ff[1];
  wire       addr_sys = (b1 == ADDR_SYS);
  wire       addr_usr = (b1[7:4] == ADDR_HI_ZERO);
  wire [3:0] blk      = b1[3:0];
  wire [31:0] wdata   = {buf_ff[5], buf_ff[4], buf_ff[3], buf_ff[2]};

  wire is_wake   = rx_cnt_ff == LEN_TWO && b0 == CMD_WAKE && b1 == SUB_WAKE;
  wire is_poll   = rx_cnt_ff == LEN_TWO && b0 == CMD_WAKE && b1 == SUB_POLL;
  wire is_slot   = rx_cnt_ff == LEN_ONE && b0[3:0] == SLOT_CODE
                   && b0[7:4] != SLOT_NONE;
  wire is_fetch  = rx_cnt_ff == LEN_TWO && b0 == CMD_FETCH
                   && (addr_sys || addr_usr);
  wire is_store  = rx_cnt_ff == LEN_STORE && b0 == CMD_STORE
                   && (addr_sys || addr_usr);
  wire is_serial = rx_cnt_ff == LEN_ONE && b0 == CMD_SERIAL;
  wire is_pick   = rx_cnt_ff == LEN_TWO && b0 == CMD_PICK;
  wire is_retire = rx_cnt_ff == LEN_ONE && b0 == CMD_RETIRE;
  wire pick_hit  = is_pick && b1 == handle_ff;

  wire in_idle   = state_ff == ST_IDLE;
  wire in_sort   = state_ff == ST_SORT;
  wire in_active = state_ff == ST_ACTIVE;
  wire in_parked = state_ff == ST_PARKED;

  // Random source and next handle values
  wire        lfsr_fb  = lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10];
  wire [7:0]  rnd_hdl  = MASK_EN ? sys_ff[HANDLE_W-1:0] : lfsr_ff[7:0];
  wire [3:0]  rnd_nib  = MASK_EN ? handle_ff[NIB_W-1:0] : lfsr_ff[11:8];
  wire [7:0]  poll_hdl = {handle_ff[7:4], rnd_nib};

  wire do_wake   = frame_ok && is_wake && (in_idle || in_sort);
  wire do_poll   = frame_ok && is_poll && in_sort;
  wire do_slot   = frame_ok && is_slot && in_sort;
  wire slot_hit  = do_slot && b0[7:4] == handle_ff[NIB_W-1:0];
  wire poll_hit  = do_poll && rnd_nib == SLOT_NONE;
  wire do_pick   = frame_ok && pick_hit
                   && (in_sort || in_active || in_parked);
  wire do_fetch  = frame_ok && is_fetch && in_active;
  wire do_store  = frame_ok && is_store && in_active;
  wire do_serial = frame_ok && is_serial && in_active;
  wire sys_frozen = (sys_ff == WORD_EMPTY);
  wire sys_wr    = do_store && addr_sys && !sys_frozen;
  wire mem_we    = do_store && addr_usr && lock_ff[blk];

  // Tag state transitions; anything not listed is dropped
  always_comb begin
    nxt_state = state_ff;
    if (frame_ok) begin
      unique case (state_ff)
        ST_IDLE:    if (is_wake) nxt_state = ST_SORT;
        ST_SORT:    if (pick_hit) nxt_state = ST_ACTIVE;
        ST_ACTIVE: begin
          if (is_pick && !pick_hit) nxt_state = ST_PARKED;
          else if (is_retire) nxt_state = ST_RETIRED;
        end
        ST_PARKED:  if (pick_hit) nxt_state = ST_ACTIVE;
        ST_RETIRED: nxt_state = ST_RETIRED;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff <= ST_IDLE;
      lfsr_ff  <= LFSR_SEED;
    end else begin
      state_ff <= nxt_state;
      lfsr_ff  <= {lfsr_ff[14:0], lfsr_fb};
    end
  end

  // Handle: fresh in idle, on wake in sorting, nibble on poll
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      handle_ff <= 8'h00;
    end else if (in_idle && !do_wake) begin
      handle_ff <= rnd_hdl;
    end else if (do_wake) begin
      handle_ff <= rnd_hdl;
    end else if (do_poll) begin
      handle_ff <= poll_hdl;
    end
  end

  // System word and the lock image used by the store path
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sys_ff  <= SYS_RESET;
      lock_ff <= LOCK_RESET;
    end else begin
      if (sys_wr) begin
        sys_ff <= sys_ff & wdata;
      end
      if (do_pick) begin
        lock_ff <= sys_ff[LOCK_LSB +: LOCK_W];
      end
    end
  end

  tag_block_mem #(
    .WIDTH (WORD_W),
    .DEPTH (BLOCKS),
    .AW    (NIB_W),
    .INIT  (SYS_RESET)
  ) u_mem (
    .clk_i   (CLK_I),
    .we_i    (mem_we),
    .addr_i  (blk),
    .wdata_i (wdata),
    .rdata_o (mem_rdata)
  );

  // Fetch waits one cycle for the registered memory read
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fetch_ff     <= 1'b0;
      fetch_sys_ff <= 1'b0;
    end else begin
      fetch_ff     <= do_fetch;
      fetch_sys_ff <= do_fetch && addr_sys;
    end
  end

  // Answer load selection
  wire        ans_hdl  = do_wake || poll_hit || slot_hit || do_pick;
  wire [31:0] fetch_w  = fetch_sys_ff ? sys_ff : mem_rdata;
  wire        ans_load = ans_hdl || fetch_ff || do_serial;
  wire [7:0]  hdl_val  = do_wake ? rnd_hdl : (do_poll ? poll_hdl : handle_ff);
  wire [63:0] ans_val  = fetch_ff  ? {32'h0000_0000, fetch_w} :
                         do_serial ? UID_VALUE : {56'h0, hdl_val};
  wire [3:0]  ans_len  = fetch_ff  ? ANS_WORD :
                         do_serial ? ANS_UID : ANS_HANDLE;
  wire        tx_take  = TX_VALID_O && TX_READY_I;

  // Answer framing: SOF, data bytes low first, CRC request, EOF
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_ff      <= TX_IDLE;
      ans_ff     <= 64'h0;
      ans_cnt_ff <= 4'h0;
    end else begin
      unique case (tx_ff)
        TX_IDLE: if (ans_load) begin
          tx_ff      <= TX_SOF;
          ans_ff     <= ans_val;
          ans_cnt_ff <= ans_len;
        end
        TX_SOF:  if (tx_take) tx_ff <= TX_DATA;
        TX_DATA: if (tx_take) begin
          ans_ff     <= {8'h00, ans_ff[63:8]};
          ans_cnt_ff <= ans_cnt_ff - 4'h1;
          if (ans_cnt_ff == ANS_HANDLE) tx_ff <= TX_CRC;
        end
        TX_CRC:  if (tx_take) tx_ff <= TX_EOF;
        TX_EOF:  if (tx_take) tx_ff <= TX_IDLE;
        default: tx_ff <= TX_IDLE;
      endcase
    end
  end

  assign TX_VALID_O = (tx_ff != TX_IDLE);
  assign TX_KIND_O  = (tx_ff == TX_SOF)  ? KIND_SOF :
                      (tx_ff == TX_DATA) ? KIND_DATA :
                      (tx_ff == TX_CRC)  ? KIND_CRC : KIND_EOF;
  assign TX_DATA_O  = ans_ff[7:0];
  assign STATE_O    = state_ff;
  assign HANDLE_O   = handle_ff;
  assign LOCK_O     = lock_ff;

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  property p_no_erase;
    1'b1 |=> ((sys_ff & ~$past(sys_ff)) == WORD_EMPTY);
  endproperty
  a_no_erase: assert property (p_no_erase)
    else $error("system word gained a one");

  property p_frozen;
    (sys_frozen && do_store && addr_sys) |=> sys_ff == WORD_EMPTY;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("empty system word changed");

  property p_protect;
    (do_store && addr_usr && !lock_ff[blk]) |-> !mem_we;
  endproperty
  a_protect: assert property (p_protect)
    else $error("store reached a protected block");

  property p_lock_load;
    !$stable(lock_ff) |-> $past(do_pick);
  endproperty
  a_lock_load: assert property (p_lock_load)
    else $error("lock image changed without pick");

  property p_idle_deaf;
    (in_idle && frame_ok && !is_wake) |=> in_idle && tx_ff == TX_IDLE;
  endproperty
  a_idle_deaf: assert property (p_idle_deaf)
    else $error("idle tag reacted to a command");

  property p_wake;
    do_wake |=> state_ff == ST_SORT && tx_ff == TX_SOF
                && TX_VALID_O ##0 (handle_ff == $past(hdl_val));
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake-query not answered from sorting");

  property p_pick_sort;
    (in_sort && frame_ok && pick_hit) |=> state_ff == ST_ACTIVE;
  endproperty
  a_pick_sort: assert property (p_pick_sort)
    else $error("matching pick did not activate");

  property p_active_deaf;
    (in_active && frame_ok && (is_wake || is_poll || is_slot))
      |=> tx_ff == TX_IDLE && state_ff == ST_ACTIVE;
  endproperty
  a_active_deaf: assert property (p_active_deaf)
    else $error("active tag answered anticollision");

  property p_park;
    (in_active && frame_ok && is_pick && !pick_hit)
      |=> state_ff == ST_PARKED ##1 state_ff == ST_PARKED || frame_ok;
  endproperty
  a_park: assert property (p_park)
    else $error("foreign pick did not park");

  property p_retired;
    state_ff == ST_RETIRED |=> state_ff == ST_RETIRED && tx_ff != TX_SOF;
  endproperty
  a_retired: assert property (p_retired)
    else $error("retired tag left its state");

  property p_poll;
    do_poll |=> (tx_ff == TX_SOF) == (handle_ff[NIB_W-1:0] == SLOT_NONE);
  endproperty
  a_poll: assert property (p_poll)
    else $error("poll answer disagrees with slot nibble");

  property p_frame_order;
    (tx_ff == TX_DATA && tx_take && ans_cnt_ff == ANS_HANDLE)
      |=> tx_ff == TX_CRC ##1 (tx_ff == TX_CRC || tx_ff == TX_EOF);
  endproperty
  a_frame_order: assert property (p_frame_order)
    else $error("CRC request not after last data byte");

  c_select: cover property (in_sort ##1 in_active);
  c_poll_hit: cover property (poll_hit);
  c_fetch: cover property (fetch_ff ##1 tx_ff == TX_SOF);
  c_retire: cover property (in_active ##1 state_ff == ST_RETIRED);
endmodule : tag_proto_ctrl

/* File: src/tag_ctrl_pkg.sv */
// Constants and types shared by the tag protocol controller
package tag_ctrl_pkg;
  localparam logic [7:0] CMD_WAKE     = 8'h06;
  localparam logic [7:0] SUB_WAKE     = 8'h00;
  localparam logic [7:0] SUB_POLL     = 8'h04;
  localparam logic [3:0] SLOT_CODE    = 4'h6;
  localparam logic [3:0] SLOT_NONE    = 4'h0;
  localparam logic [7:0] CMD_FETCH    = 8'h08;
  localparam logic [7:0] CMD_STORE    = 8'h09;
  localparam logic [7:0] CMD_SERIAL   = 8'h0b;
  localparam logic [7:0] CMD_PICK     = 8'h0e;
  localparam logic [7:0] CMD_RETIRE   = 8'h0f;
  localparam logic [7:0] ADDR_SYS     = 8'hff;
  localparam logic [3:0] ADDR_HI_ZERO = 4'h0;
  localparam logic [2:0] LEN_ONE      = 3'h1;
  localparam logic [2:0] LEN_TWO      = 3'h2;
  localparam logic [2:0] LEN_STORE    = 3'h6;
  localparam logic [2:0] LEN_OVER     = 3'h7;
  localparam int         RX_BYTES     = 6;
  localparam logic [3:0] ANS_HANDLE   = 4'h1;
  localparam logic [3:0] ANS_WORD     = 4'h4;
  localparam logic [3:0] ANS_UID      = 4'h8;
  localparam int         LOCK_LSB     = 16;
  localparam int         LOCK_W       = 16;
  localparam int         HANDLE_W     = 8;
  localparam int         NIB_W        = 4;
  localparam int         WORD_W       = 32;
  localparam int         BLOCKS       = 16;
  localparam logic [31:0] WORD_EMPTY  = 32'h0000_0000;
  localparam logic [15:0] LOCK_RESET  = 16'h0000;
  localparam logic [15:0] LFSR_SEED   = 16'hace1;
  localparam logic [1:0] KIND_SOF     = 2'h0;
  localparam logic [1:0] KIND_DATA    = 2'h1;
  localparam logic [1:0] KIND_CRC     = 2'h2;
  localparam logic [1:0] KIND_EOF     = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SORT, ST_ACTIVE, ST_PARKED, ST_RETIRED
  } tag_state_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_SOF, TX_DATA, TX_CRC, TX_EOF
  } tx_state_t;
endpackage : tag_ctrl_pkg

/* File: src/tag_block_mem.sv */
// User block store with registered read data
`timescale 1ns/100ps
module tag_block_mem #(
  parameter int          WIDTH = 32,
  parameter int          DEPTH = 16,
  parameter int          AW    = 4,
  parameter logic [31:0] INIT  = 32'hffff_ffff
) (
  input  wire logic             clk_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    addr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_ff [0:DEPTH-1];

  // Fresh part content
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_ff[i] = INIT[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[addr_i] <= wdata_i;
    end
    rdata_o <= mem_ff[addr_i];
  end
endmodule : tag_block_mem

/* File: verif/reader_model.sv */
// Reader controller model: frames requests, stalls and collects answers
`timescale 1ns/100ps
module reader_model
  import tag_ctrl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       tx_valid_i,
  input  wire logic [1:0] tx_kind_i,
  input  wire logic [7:0] tx_data_i,
  output logic            rx_sof_o,
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_eof_o,
  output logic            rx_crc_ok_o,
  output logic            tx_ready_o
);
  logic [7:0] ans_q[$];
  int         fr_err;
  logic       in_frame;
  logic       saw_crc;
  logic       slow;

  initial begin
    rx_sof_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_eof_o = 1'b0;
    rx_crc_ok_o = 1'b0;
    tx_ready_o = 1'b1;
    fr_err = 0;
    in_frame = 1'b0;
    saw_crc = 1'b0;
    slow = 1'b0;
  end

  // Slow mode takes an answer element every other cycle
  always @(posedge clk_i) tx_ready_o <= slow ? ~tx_ready_o : 1'b1;

  // Answer order: SOF, data, CRC request, EOF
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      case (tx_kind_i)
        KIND_SOF: begin
          if (in_frame) fr_err++;
          in_frame = 1'b1;
          saw_crc = 1'b0;
        end
        KIND_DATA: begin
          if (!in_frame || saw_crc) fr_err++;
          ans_q.push_back(tx_data_i);
        end
        KIND_CRC: begin
          if (!in_frame || saw_crc) fr_err++;
          saw_crc = 1'b1;
        end
        default: begin
          if (!in_frame || !saw_crc) fr_err++;
          in_frame = 1'b0;
        end
      endcase
    end
  end

  // Request: SOF, command bytes, CRC verdict with EOF, then the answer
  task automatic send(input logic [47:0] b, input int n,
                      input logic crc);
    int i;
    ans_q.delete();
    @(posedge clk_i);
    rx_sof_o <= 1'b1;
    for (i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_sof_o   <= 1'b0;
      rx_valid_o <= 1'b1;
      rx_data_o  <= b[8*i +: 8];
    end
    @(posedge clk_i);
    rx_sof_o    <= 1'b0;
    rx_valid_o  <= 1'b0;
    rx_data_o   <= ~rx_data_o;
    rx_eof_o    <= 1'b1;
    rx_crc_ok_o <= crc;
    @(posedge clk_i);
    rx_eof_o    <= 1'b0;
    rx_crc_ok_o <= ~crc;
    repeat (3) @(negedge clk_i);
    for (i = 0; i < 80 && tx_valid_i; i++) @(negedge clk_i);
  endtask : send
endmodule : reader_model

/* File: verif/test_contactless_tag_state_anticollision.sv */
// Self-checking bench for the tag protocol controller
`timescale 1ns/100ps
module test_contactless_tag_state_anticollision
  import tag_ctrl_pkg::*;
;
  localparam logic [63:0] UID   = 64'h0123_4567_89ab_cdef;
  localparam logic [31:0] SYS_M = 32'hffff_ff5a;
  localparam logic [47:0] WAKE  = {32'h0, SUB_WAKE, CMD_WAKE};
  localparam logic [47:0] POLL  = {32'h0, SUB_POLL, CMD_WAKE};
  localparam logic [47:0] SER   = {40'h0, CMD_SERIAL};

  logic        clk;
  logic        rst;
  logic        sof;
  logic        vld;
  logic [7:0]  dat;
  logic        eof;
  logic        crc;
  logic        rdy;
  logic        txv;
  logic [1:0]  kind;
  logic [7:0]  txd;
  logic [2:0]  state;
  logic [7:0]  handle;
  logic [7:0]  handle_m;
  logic [15:0] lock;
  logic [7:0]  hn;
  int          n_fail;
  int          num_checks;
  int          p;
  int          s;

  tag_proto_ctrl #(.UID_VALUE(UID)) dut (
    .CLK_I(clk), .RST_I(rst), .RX_SOF_I(sof), .RX_VALID_I(vld),
    .RX_DATA_I(dat), .RX_EOF_I(eof), .RX_CRC_OK_I(crc),
    .TX_READY_I(rdy), .TX_VALID_O(txv), .TX_KIND_O(kind),
    .TX_DATA_O(txd), .STATE_O(state), .HANDLE_O(handle), .LOCK_O(lock)
  );

  // Mask option copy sees the same requests; only its handle is watched
  tag_proto_ctrl #(.MASK_EN(1'b1), .SYS_RESET(SYS_M)) dut_mask (
    .CLK_I(clk), .RST_I(rst), .RX_SOF_I(sof), .RX_VALID_I(vld),
    .RX_DATA_I(dat), .RX_EOF_I(eof), .RX_CRC_OK_I(crc),
    .TX_READY_I(rdy), .TX_VALID_O(), .TX_KIND_O(), .TX_DATA_O(),
    .STATE_O(), .HANDLE_O(handle_m), .LOCK_O()
  );

  reader_model r (
    .clk_i(clk), .tx_valid_i(txv), .tx_kind_i(kind), .tx_data_i(txd),
    .rx_sof_o(sof), .rx_valid_o(vld), .rx_data_o(dat), .rx_eof_o(eof),
    .rx_crc_ok_o(crc), .tx_ready_o(rdy)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One request; a one-byte answer must carry the current handle
  task automatic xfer(input logic [47:0] b, input int n, input logic ok,
                      input int len, input logic [63:0] val);
    logic [63:0] got;
    int i;
    r.send(b, n, ok);
    got = 64'h0;
    for (i = 0; i < r.ans_q.size() && i < 8; i++) got[8*i +: 8] = r.ans_q[i];
    if (len == 1) val = 64'(handle);
    check("answer bytes", 64'(r.ans_q.size()), 64'(len));
    check("answer value", got, val);
    check("answer framing", 64'(r.fr_err), 64'h0);
  endtask : xfer

  task automatic st(input logic [2:0] exp);
    check("state", 64'(state), 64'(exp));
  endtask : st

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial begin
    n_fail = 0;
    num_checks = 0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    st(3'h0);
    check("reset lock", 64'(lock), 64'h0);
    xfer(POLL, 2, 1'b1, 0, 0);
    xfer({40'h0, 4'h1, SLOT_CODE}, 1, 1'b1, 0, 0);
    xfer({32'h0, handle, CMD_PICK}, 2, 1'b1, 0, 0);
    xfer(SER, 1, 1'b1, 0, 0);
    xfer(WAKE, 2, 1'b0, 0, 0);
    xfer({40'h0, 8'h55}, 1, 1'b1, 0, 0);
    st(3'h0);
    $display("test idle done");
    xfer(WAKE, 2, 1'b1, 1, 0);
    st(3'h1);
    check("mask handle", 64'(handle_m), 64'(SYS_M[7:0]));
    xfer(WAKE, 2, 1'b1, 1, 0);
    for (p = 0; p < 24; p++) begin
      hn = handle;
      r.send(POLL, 2, 1'b1);
      check("poll hit", 64'(r.ans_q.size()), 64'(handle[3:0] == 4'h0));
      check("upper handle", 64'(handle[7:4]), 64'(hn[7:4]));
      for (s = 1; s < 16 && p < 2; s++) begin
        hn = handle;
        xfer({40'h0, 4'(s), SLOT_CODE}, 1, 1'b1,
             (handle[3:0] == 4'(s)) ? 1 : 0, 0);
        check("nibble held", 64'(handle), 64'(hn));
      end
    end
    check("mask handle", 64'(handle_m), 64'(SYS_M[7:0]));
    st(3'h1);
    $display("test sorting done");
    hn = handle;
    xfer({32'h0, ~hn, CMD_PICK}, 2, 1'b1, 0, 0);
    st(3'h1);
    xfer({32'h0, hn, CMD_PICK}, 2, 1'b1, 1, 0);
    st(3'h2);
    check("lock", 64'(lock), 64'hffff);
    xfer(WAKE, 2, 1'b1, 0, 0);
    xfer(POLL, 2, 1'b1, 0, 0);
    xfer({40'h0, hn[3:0], SLOT_CODE}, 1, 1'b1, 0, 0);
    r.slow = 1'b1;
    xfer(SER, 1, 1'b1, 8, UID);
    r.slow = 1'b0;
    xfer({32'h1234_5678, 8'h07, CMD_STORE}, 6, 1'b1, 0, 0);
    xfer({32'h0, 8'h07, CMD_FETCH}, 2, 1'b1, 4, 64'h1234_5678);
    xfer({32'h1111_1111, 8'h00, CMD_STORE}, 6, 1'b1, 0, 0);
    xfer({32'hfffe_ffff, ADDR_SYS, CMD_STORE}, 6, 1'b1, 0, 0);
    xfer({32'h0, ADDR_SYS, CMD_FETCH}, 2, 1'b1, 4, 64'hfffe_ffff);
    check("lock", 64'(lock), 64'hffff);
    xfer({32'hffff_ffff, ADDR_SYS, CMD_STORE}, 6, 1'b1, 0, 0);
    xfer({32'h0, ADDR_SYS, CMD_FETCH}, 2, 1'b1, 4, 64'hfffe_ffff);
    xfer({32'h0, hn, CMD_PICK}, 2, 1'b1, 1, 0);
    check("lock", 64'(lock), 64'hfffe);
    xfer({32'h2222_2222, 8'h00, CMD_STORE}, 6, 1'b1, 0, 0);
    xfer({32'h0, 8'h00, CMD_FETCH}, 2, 1'b1, 4, 64'h1111_1111);
    xfer({32'h3333_3333, 8'h01, CMD_STORE}, 6, 1'b1, 0, 0);
    xfer({32'h0, 8'h01, CMD_FETCH}, 2, 1'b1, 4, 64'h3333_3333);
    xfer({32'h0000_0000, ADDR_SYS, CMD_STORE}, 6, 1'b1, 0, 0);
    xfer({32'hffff_ffff, ADDR_SYS, CMD_STORE}, 6, 1'b1, 0, 0);
    xfer({32'h0, ADDR_SYS, CMD_FETCH}, 2, 1'b1, 4, 64'h0);
    $display("test active done");
    xfer({32'h0, ~hn, CMD_PICK}, 2, 1'b1, 0, 0);
    st(3'h3);
    xfer(SER, 1, 1'b1, 0, 0);
    xfer(WAKE, 2, 1'b1, 0, 0);
    xfer({32'h0, 8'h07, CMD_FETCH}, 2, 1'b1, 0, 0);
    st(3'h3);
    xfer({32'h0, hn, CMD_PICK}, 2, 1'b1, 1, 0);
    st(3'h2);
    check("lock", 64'(lock), 64'h0);
    xfer({32'h4444_4444, 8'h01, CMD_STORE}, 6, 1'b1, 0, 0);
    xfer({32'h0, 8'h01, CMD_FETCH}, 2, 1'b1, 4, 64'h3333_3333);
    xfer({40'h0, CMD_RETIRE}, 1, 1'b1, 0, 0);
    st(3'h4);
    xfer({32'h0, hn, CMD_PICK}, 2, 1'b1, 0, 0);
    xfer(WAKE, 2, 1'b1, 0, 0);
    xfer(SER, 1, 1'b1, 0, 0);
    st(3'h4);
    $display("test parked and retired done");
    @(posedge clk);
    rst <= 1'b1;
    xfer(WAKE, 2, 1'b1, 0, 0);
    st(3'h0);
    @(posedge clk);
    rst <= 1'b0;
    xfer(WAKE, 2, 1'b1, 1, 0);
    st(3'h1);
    $display("test power cycle done");
    conclude();
  end
endmodule : test_contactless_tag_state_anticollision
